//--- hdl/reset_strap_capture.sv
// strap capture: samples the strap pins during reset, holds them after release
// assumes strap pins are asynchronous; avalon-mm slave answers reads after one wait cycle
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/100ps
module reset_strap_capture (
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  input  wire logic [31:0]                 strap_pins,
  input  wire logic                        test_n,
  input  wire logic [strap_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest,
  output logic                             board_test_q,
  output logic                             gate_chain_test_q,
  output logic [1:0]                       forward_clock_phase_q,
  output logic [3:0]                       serial_init_stream_q,
  output logic [1:0]                       receiver_hysteresis_select_q,
  output logic                             card_kind_detect_n_q
);
  localparam int SW = strap_pkg::STRAP_HI - strap_pkg::STRAP_LO + 1;

  // three-stage synchroniser on the strap pins; stage 1 feeds stage 2 only.
  // no reset here on purpose: an async clear would pin all stages at zero
  // for the whole reset window, and the window is exactly when the pulls
  // must flow through to the capture latch
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  logic [SW-1:0] s3_q;
  always_ff @(posedge core_clk) begin
    s1_q <= strap_pins[strap_pkg::STRAP_HI:strap_pkg::STRAP_LO];
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // three-stage synchroniser on the test pin; clears to the inactive level
  logic t1_q;
  logic t2_q;
  logic t3_q;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      t1_q <= 1'b1;
      t2_q <= 1'b1;
      t3_q <= 1'b1;
    end else begin
      t1_q <= test_n;
      t2_q <= t1_q;
      t3_q <= t2_q;
    end
  end

  // agreed test level: changes only when stages 2 and 3 match
  logic test_n_q;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) test_n_q <= 1'b1;
    else if (t2_q == t3_q) test_n_q <= t3_q;
  end

  // reset held in a sync'd flag so sampling continues while reset is high;
  // async reset cannot load pins, so capture runs clocked in the reset window
  logic rst_s1_q, rst_s2_q;
  always_ff @(posedge core_clk) begin
    rst_s1_q <= reset;
    rst_s2_q <= rst_s1_q;
  end
  logic in_reset;
  assign in_reset = rst_s2_q;

  // sample pins during reset; freeze from release until next reset
  logic [SW-1:0] latched_q;
  logic          valid_q;
  always_ff @(posedge core_clk) begin
    if (in_reset && s2_q == s3_q) begin
      latched_q <= s3_q;
    end
    valid_q <= !in_reset;
  end

  localparam int I_TS = strap_pkg::POS_THREE_STATE - strap_pkg::STRAP_LO;
  localparam int I_CD = strap_pkg::POS_CLK_DELAY   - strap_pkg::STRAP_LO;
  localparam int I_GC = strap_pkg::POS_GATE_CHAIN  - strap_pkg::STRAP_LO;
  localparam int I_HH = strap_pkg::POS_HYST_HI     - strap_pkg::STRAP_LO;
  localparam int I_HL = strap_pkg::POS_HYST_LO     - strap_pkg::STRAP_LO;
  localparam int I_CK = strap_pkg::POS_CARD_KIND   - strap_pkg::STRAP_LO;

  // decoded controls; held at safe defaults until capture is complete
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      board_test_q                 <= 1'b0;
      gate_chain_test_q            <= 1'b0;
      forward_clock_phase_q        <= strap_pkg::ZERO_PHASES;
      serial_init_stream_q         <= strap_pkg::SIS_EDGE_ALIGNED;
      receiver_hysteresis_select_q <= strap_pkg::HYST_LOW;
      card_kind_detect_n_q         <= 1'b1;
    end else if (valid_q) begin
      board_test_q      <= latched_q[I_TS] && !test_n_q;
      gate_chain_test_q <= latched_q[I_GC] && !test_n_q;
      // quarter-period phase shift centres the edge in the data eye
      forward_clock_phase_q <= latched_q[I_CD] ? strap_pkg::QUARTER_PHASES
                                               : strap_pkg::ZERO_PHASES;
      serial_init_stream_q  <= latched_q[I_CD] ? strap_pkg::SIS_CENTER_SHIFT
                                               : strap_pkg::SIS_EDGE_ALIGNED;
      receiver_hysteresis_select_q <= {latched_q[I_HH], latched_q[I_HL]};
      card_kind_detect_n_q <= latched_q[I_CK];
    end
  end

  // avalon slave: one wait cycle, then answer; unmapped reads return zero
  logic pend_q;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pend_q          <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= strap_pkg::UNMAPPED_DATA;
    end else if ((avs_read || avs_write) && !pend_q) begin
      pend_q          <= 1'b1;
      avs_waitrequest <= 1'b0;
      avs_readdata    <= strap_pkg::UNMAPPED_DATA;
      if (avs_read && avs_address == strap_pkg::STATUS_OFFSET)
        avs_readdata[strap_pkg::STRAP_HI:strap_pkg::STRAP_LO] <= latched_q;
    end else begin
      pend_q          <= 1'b0;
      avs_waitrequest <= 1'b1;
    end
  end

  // all assertions run on the core clock and are masked while reset is high;
  // the status register is read-only, so writes are acknowledged and dropped
  // frozen latch: pin traffic after release must never leak into it
  property p_frozen;
    @(posedge core_clk) disable iff (reset)
    valid_q && $past(valid_q) |-> $stable(latched_q);
  endproperty
  a_frozen: assert property (p_frozen) else $error("strap latch moved");
  // capture window: an agreed pin level is taken on the next edge
  property p_capture;
    @(posedge core_clk) disable iff (reset)
    in_reset && s2_q == s3_q |=> latched_q == $past(s3_q);
  endproperty
  a_capture: assert property (p_capture) else $error("strap capture missed");
  // forwarded clock placement follows the delay strap
  property p_phase;
    @(posedge core_clk) disable iff (reset)
    valid_q ##1 valid_q |-> forward_clock_phase_q ==
      ($past(latched_q[I_CD]) ? strap_pkg::QUARTER_PHASES : strap_pkg::ZERO_PHASES);
  endproperty
  a_phase: assert property (p_phase) else $error("clock phase wrong");
  // init stream code tracks the clock placement
  property p_sis;
    @(posedge core_clk) disable iff (reset)
    valid_q ##1 valid_q |-> (serial_init_stream_q == strap_pkg::SIS_CENTER_SHIFT)
      == forward_clock_phase_q[0];
  endproperty
  a_sis: assert property (p_sis) else $error("init stream mismatch");
  // board test needs both the strap and an asserted test pin
  property p_board;
    @(posedge core_clk) disable iff (reset)
    valid_q ##1 valid_q |-> board_test_q ==
      ($past(latched_q[I_TS]) && !$past(test_n_q));
  endproperty
  a_board: assert property (p_board) else $error("board test wrong");
  // gate-chain test follows the same qualification
  property p_gate;
    @(posedge core_clk) disable iff (reset)
    valid_q ##1 valid_q |-> gate_chain_test_q ==
      ($past(latched_q[I_GC]) && !$past(test_n_q));
  endproperty
  a_gate: assert property (p_gate) else $error("gate chain wrong");
  // hysteresis code passes through unchanged
  property p_hyst;
    @(posedge core_clk) disable iff (reset)
    valid_q ##1 valid_q |-> receiver_hysteresis_select_q == $past(latched_q[I_HH:I_HL]);
  endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis wrong");
  // card kind detect is the latched level as is
  property p_card;
    @(posedge core_clk) disable iff (reset)
    valid_q ##1 valid_q |-> card_kind_detect_n_q == $past(latched_q[I_CK]);
  endproperty
  a_card: assert property (p_card) else $error("card detect wrong");
  // status read answers after one wait cycle with the latched straps
  property p_read;
    @(posedge core_clk) disable iff (reset)
    avs_read && !pend_q && avs_address == strap_pkg::STATUS_OFFSET |=>
      !avs_waitrequest &&
      avs_readdata[strap_pkg::STRAP_HI:strap_pkg::STRAP_LO] == $past(latched_q);
  endproperty
  a_read: assert property (p_read) else $error("status read wrong");
  // reads of any other offset return the unmapped value
  property p_unmapped;
    @(posedge core_clk) disable iff (reset)
    avs_read && !pend_q && avs_address != strap_pkg::STATUS_OFFSET |=>
      avs_readdata == strap_pkg::UNMAPPED_DATA;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read wrong");
  // the answer stands exactly one cycle, so a held request is never taken twice
  property p_ack_once;
    @(posedge core_clk) disable iff (reset)
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("answer held too long");
  // an idle bus keeps waitrequest high
  property p_idle_wait;
    @(posedge core_clk) disable iff (reset)
    !avs_read && !avs_write |=> avs_waitrequest;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("answer without request");
  // main scenarios: delayed clocks, both test modes, answered read at any offset, dropped write
  c_delay: cover property (@(posedge core_clk) valid_q && latched_q[I_CD]);
  c_test:  cover property (@(posedge core_clk) board_test_q);
  c_read:  cover property (@(posedge core_clk) avs_read && !avs_waitrequest);
  c_gate:  cover property (@(posedge core_clk) gate_chain_test_q);
  c_write: cover property (@(posedge core_clk) avs_write && !avs_waitrequest);
endmodule : reset_strap_capture

//--- include/strap_pkg.sv
// constants for the reset-time strap capture block
// assumes a 32-bit avalon-mm register port and a 250 MHz core clock
package strap_pkg;
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  STATUS_OFFSET   = 8'h88;
  // strap bit positions on the shared address/data pins
  localparam int          POS_THREE_STATE = 25;
  localparam int          POS_CLK_DELAY   = 24;
  localparam int          POS_GATE_CHAIN  = 23;
  localparam int          POS_HYST_HI     = 22;
  localparam int          POS_HYST_LO     = 21;
  localparam int          POS_CARD_KIND   = 20;
  localparam int          STRAP_HI        = 25;
  localparam int          STRAP_LO        = 20;
  localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;
  // hysteresis codes
  localparam logic [1:0]  HYST_NONE       = 2'h0;
  localparam logic [1:0]  HYST_LOW        = 2'h1;
  localparam logic [1:0]  HYST_MEDIUM     = 2'h2;
  localparam logic [1:0]  HYST_MAXIMUM    = 2'h3;
  // serial init stream field values for the two clock placements
  localparam logic [3:0]  SIS_EDGE_ALIGNED  = 4'h0;
  localparam logic [3:0]  SIS_CENTER_SHIFT  = 4'h1;
  localparam logic [1:0]  QUARTER_PHASES  = 2'h1;
  localparam logic [1:0]  ZERO_PHASES     = 2'h0;
endpackage : strap_pkg

//--- tb/reset_strap_capture_bench.sv
// bench for the strap capture block: random straps, status reads, hold after reset
// assumes the package, the design and the pull model are compiled first
`timescale 1ns/100ps
module reset_strap_capture_bench;
  logic        core_clk      = 1'b0;
  logic        reset         = 1'b1;
  logic        test_n        = 1'b1;
  logic [31:0] pull_levels   = 32'h0;
  logic [7:0]  avs_address   = 8'h00;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] strap_pins, avs_readdata, rd;
  logic        avs_waitrequest, board_test_q, gate_chain_test_q, card_kind_detect_n_q;
  logic [1:0]  forward_clock_phase_q, receiver_hysteresis_select_q;
  logic [3:0]  serial_init_stream_q;
  int          failures      = 0;
  int          check_count   = 0;
  int          pat;
  always #2 core_clk = ~core_clk;
  strap_pull_model pulls (.core_clk, .reset, .pull_levels, .strap_pins);
  reset_strap_capture dut (.core_clk, .reset, .strap_pins, .test_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
    .board_test_q, .gate_chain_test_q, .forward_clock_phase_q, .serial_init_stream_q,
    .receiver_hysteresis_select_q, .card_kind_detect_n_q);
  task final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one avalon transfer; held until waitrequest is sampled low, bounded wait
  task bus(input logic wr, input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge core_clk);
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_address   <= a;
    avs_writedata <= $urandom;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    d = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      final_report();
    end
  endtask : bus
  // each pass: new straps under reset, decoded outputs, status reads, write ignored
  initial begin
    void'($urandom(32'h4603a2c9));
    for (int i = 0; i < 8; i++) begin
      pat = $urandom;
      pat[22:21] = i[1:0];
      @(posedge core_clk);
      reset       <= 1'b1;
      pull_levels <= pat;
      test_n      <= i[2];
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      repeat (12) @(posedge core_clk);
      check(board_test_q, pat[25] & !i[2]);
      check(gate_chain_test_q, pat[23] & !i[2]);
      check(forward_clock_phase_q, pat[24] ? strap_pkg::QUARTER_PHASES
        : strap_pkg::ZERO_PHASES);
      check(serial_init_stream_q, pat[24] ? strap_pkg::SIS_CENTER_SHIFT
        : strap_pkg::SIS_EDGE_ALIGNED);
      check(receiver_hysteresis_select_q, pat[22:21]);
      check(card_kind_detect_n_q, pat[20]);
      bus(1'b0, strap_pkg::STATUS_OFFSET, rd);
      check(rd, pat & 32'h03F0_0000);
      bus(1'b1, strap_pkg::STATUS_OFFSET, rd);
      bus(1'b0, strap_pkg::STATUS_OFFSET, rd);
      check(rd, pat & 32'h03F0_0000);
      bus(1'b0, 8'h40, rd);
      check(rd, strap_pkg::UNMAPPED_DATA);
      $display("test %0d done", i);
    end
    final_report();
  end
endmodule : reset_strap_capture_bench

//--- tb/strap_pull_model.sv
// board pull resistors on the shared address/data pins
// assumes the bench holds pull_levels steady while reset is high
`timescale 1ns/100ps
module strap_pull_model (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [31:0] pull_levels,
  output logic      [31:0] strap_pins
);
  // pulls only win while reset holds the bus idle; later bus traffic toggles every cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      strap_pins <= pull_levels;
    end else begin
      strap_pins <= ~strap_pins;
    end
  end
endmodule : strap_pull_model
